// ==== rtl/rtc_pkg.sv ====
// Purpose: Shared constants for the timer counter and interrupt register block
// Assumes: AXI4-Lite with 32-bit data; register indices map to byte address index * 4
// Notes: Indices are kept as printed; the bus compares address bits 31:2 against index bits 29:0
package rtc_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Register indices
  localparam logic [31:0] IDX_PERIOD = 32'h0B0000D0;
  localparam logic [31:0] IDX_PCOUNT_LOW = 32'h0B0000D4;
  localparam logic [31:0] IDX_PCOUNT_HIGH = 32'h0B0000D6;
  localparam logic [31:0] IDX_UP_LOW = 32'h0B0000D8;
  localparam logic [31:0] IDX_UP_HIGH = 32'h0B0000DA;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h0B0000DC;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h0B0000DE;

  // Widths and field positions
  localparam int PCOUNT_W = 24;
  localparam int PCOUNT_HI_LSB = 16;
  localparam int PCOUNT_HI_W = 8;
  localparam int UP_W = 31;
  localparam int UP_SPLIT = 16;
  localparam int UP_HI_W = 15;
  localparam int UP_EN_BIT = 15;
  localparam int HALF_W = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_CMP_BIT = 1;
  localparam int IRQ_PER_BIT = 0;

  // Reset values
  localparam logic [UP_W-1:0] UP_RESET = 31'h00000000;
  localparam logic [PCOUNT_W-1:0] PERIOD_RESET = 24'h000000;
  localparam logic [PCOUNT_W-1:0] PCOUNT_RESET = 24'h000000;
  localparam logic [IRQ_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 2'h3;
  localparam logic [PCOUNT_W-1:0] PCOUNT_ONE = 24'h000001;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Nominal slow timer rate; the block only follows its edges
  localparam int TIMER_CLK_HZ = 32768;

endpackage

// ==== rtl/rtc_count_if.sv ====
// Purpose: Control and value path between the register block and the up-counter
// Assumes: One clock domain
// Notes: Load has priority over counting inside the counter
`timescale 1ns/1ps
interface rtc_count_if;
  logic tick;
  logic run;
  logic load;
  logic [rtc_pkg::UP_W-1:0] loadValue;
  logic [rtc_pkg::UP_W-1:0] value;

  modport ctrl (output tick, output run, output load, output loadValue, input value);
  modport counter (input tick, input run, input load, input loadValue, output value);
endinterface

// ==== rtl/rtc_up_counter.sv ====
// Purpose: Free-running up-counter stepped by slow timer ticks
// Assumes: tick is a one-cycle pulse in the sys_clk domain
// Notes: A diagnostic load overrides a tick in the same cycle
`timescale 1ns/1ps
module rtc_up_counter
(
  input wire logic sys_clk,
  input wire logic nrst,
  rtc_count_if.counter cnt
);

  logic [rtc_pkg::UP_W-1:0] count;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= rtc_pkg::UP_RESET; // [RQ5]
    end
    else if (cnt.load)
    begin
      count <= cnt.loadValue;
    end
    else if (cnt.run && cnt.tick)
    begin
      count <= count + 31'h00000001; // [RQ2]
    end
  end

  assign cnt.value = count;

  upcount_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cnt.run && cnt.tick && !cnt.load |=> count == $past(count) + 31'h00000001) // [RQ2]
    else $error("Up-counter did not step on a tick");

  upcount_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !cnt.run && !cnt.load |=> $stable(count)) // [RQ4]
    else $error("Stopped up-counter changed");

endmodule

// ==== rtl/rtc_counter_regs.sv ====
// Purpose: Periodic down-counter, up-counter and timer interrupt status behind AXI4-Lite
// Assumes: slowTimerClock and compareEvent are synchronous to sys_clk
// Notes: Reads answer one cycle after the address; writes answer one cycle after both halves
`timescale 1ns/1ps

// Overview of operation
// (RQ1) Counter bits 23:16 of the periodic down-counter read at bits 7:0, rest zero
// (RQ2) Up-counter holds 31 bits and steps once per slow timer tick
// (RQ3) Software writes the up-counter only for diagnostics, normally only reads it
// (RQ4) Upper bit of the up-counter pair is the run enable: 0 stops, 1 counts
// (RQ5) Reset clears the up-counter and its enable; it stays stopped until enabled
// (RQ6) Up-counter bits 15:0 in low word, 30:16 plus enable at bit 15 in high word
// (RQ7) Status bit 1 flags a compare timer interrupt, bit 0 a periodic interrupt
// (RQ8) Writing one to a clear status bit raises that interrupt from software
// (RQ9) Reserved bits are written as zero by software and always read as zero
// (RQ10) Writing one to a set status bit clears it; a same-cycle event wins
// (RQ11) Interrupt output is high while an unmasked status bit is set
// (RQ12) Periodic counter at one reloads the period on the next tick and interrupts
// (RQ13) Periodic counter is 24 bits and decrements on each slow timer tick
// (RQ14) Software reads the counters in two halves and tolerates carries between them
module rtc_counter_regs
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [rtc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [rtc_pkg::DATA_W-1:0] wdata,
  input wire logic [rtc_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rtc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [rtc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic slowTimerClock,
  input wire logic compareEvent,
  output logic irq
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  rtc_count_if upIf ();

  logic [rtc_pkg::ADDR_W-1:0] wrAddr;
  logic [rtc_pkg::DATA_W-1:0] wrData;
  logic [rtc_pkg::STRB_W-1:0] wrStrb;
  logic writeFire;
  logic timerClkSeen;
  logic tick;
  logic runEnable;
  logic [rtc_pkg::PCOUNT_W-1:0] period;
  logic [rtc_pkg::PCOUNT_W-1:0] downCount;
  logic periodicEvent;
  logic [rtc_pkg::IRQ_W-1:0] status;
  logic [rtc_pkg::IRQ_W-1:0] next_status;
  logic [rtc_pkg::IRQ_W-1:0] mask;
  logic [rtc_pkg::DATA_W-1:0] next_rdata;
  logic next_rerr;
  logic wrErr;
  logic [rtc_pkg::HALF_W-1:0] upHighView;

  // Address match against a register index
  function automatic logic hit(input logic [rtc_pkg::ADDR_W-1:0] addr, input logic [31:0] idx);
    hit = (addr[31:2] == idx[29:0]);
  endfunction

  // Merge the two low byte lanes of a write into an old 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    merge16 = res;
  endfunction

  // Write channel: address and data are taken in either order, answered once both are held
  assign writeFire = !awready && !wready && !bvalid;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready <= 1'b1;
      wrAddr <= 32'h00000000;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      wrAddr <= awaddr;
    end
    else if (bvalid && bready)
    begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wready <= 1'b1;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wrData <= wdata;
      wrStrb <= wstrb;
    end
    else if (bvalid && bready)
    begin
      wready <= 1'b1;
    end
  end

  always_comb
  begin
    wrErr = 1'b1;
    if (hit(wrAddr, rtc_pkg::IDX_PERIOD))
    begin
      wrErr = 1'b0;
    end
    else if (hit(wrAddr, rtc_pkg::IDX_PCOUNT_LOW) || hit(wrAddr, rtc_pkg::IDX_PCOUNT_HIGH))
    begin
      wrErr = 1'b0;
    end
    else if (hit(wrAddr, rtc_pkg::IDX_UP_LOW) || hit(wrAddr, rtc_pkg::IDX_UP_HIGH))
    begin
      wrErr = 1'b0;
    end
    else if (hit(wrAddr, rtc_pkg::IDX_IRQ_STATUS) || hit(wrAddr, rtc_pkg::IDX_IRQ_MASK))
    begin
      wrErr = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid <= 1'b0;
      bresp <= rtc_pkg::RESP_OKAY;
    end
    else if (writeFire)
    begin
      bvalid <= 1'b1;
      bresp <= wrErr ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
    end
    else if (bvalid && bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // Slow timer edge detect; the pin is already synchronous, so one stage suffices
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timerClkSeen <= 1'b0;
    end
    else
    begin
      timerClkSeen <= slowTimerClock;
    end
  end

  assign tick = slowTimerClock && !timerClkSeen;

  // Period register; write access to the read-only counter words is ignored
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      period <= rtc_pkg::PERIOD_RESET;
    end
    else if (writeFire && hit(wrAddr, rtc_pkg::IDX_PERIOD))
    begin
      if (wrStrb[0])
      begin
        period[7:0] <= wrData[7:0];
      end
      if (wrStrb[1])
      begin
        period[15:8] <= wrData[15:8];
      end
      if (wrStrb[2])
      begin
        period[23:16] <= wrData[23:16];
      end
    end
  end

  // Periodic down-counter; a zero period leaves it parked at zero
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      downCount <= rtc_pkg::PCOUNT_RESET;
      periodicEvent <= 1'b0;
    end
    else
    begin
      periodicEvent <= 1'b0;
      if (tick)
      begin
        if (downCount == rtc_pkg::PCOUNT_ONE)
        begin
          downCount <= period; // [RQ12]
          periodicEvent <= 1'b1; // [RQ12]
        end
        else if (downCount == rtc_pkg::PCOUNT_RESET)
        begin
          downCount <= period;
        end
        else
        begin
          downCount <= downCount - 24'h000001; // [RQ13]
        end
      end
    end
  end

  // Up-counter run enable and diagnostic loads
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      runEnable <= 1'b0; // [RQ5]
    end
    else if (writeFire && hit(wrAddr, rtc_pkg::IDX_UP_HIGH) && wrStrb[1])
    begin
      runEnable <= wrData[rtc_pkg::UP_EN_BIT]; // [RQ4]
    end
  end

  assign upHighView = {runEnable, upIf.value[rtc_pkg::UP_W-1:rtc_pkg::UP_SPLIT]}; // [RQ6]

  always_comb
  begin
    logic [15:0] hiMerged;
    hiMerged = merge16(upHighView, wrData, wrStrb);
    upIf.tick = tick;
    upIf.run = runEnable;
    upIf.load = 1'b0;
    upIf.loadValue = upIf.value;
    if (writeFire && hit(wrAddr, rtc_pkg::IDX_UP_LOW))
    begin
      upIf.load = 1'b1;
      upIf.loadValue = {upIf.value[rtc_pkg::UP_W-1:rtc_pkg::UP_SPLIT],
        merge16(upIf.value[15:0], wrData, wrStrb)}; // [RQ6]
    end
    else if (writeFire && hit(wrAddr, rtc_pkg::IDX_UP_HIGH))
    begin
      upIf.load = 1'b1;
      upIf.loadValue = {hiMerged[rtc_pkg::UP_HI_W-1:0], upIf.value[15:0]}; // [RQ6]
    end
  end

  rtc_up_counter upCounter
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cnt(upIf.counter)
  );

  // Status: a hardware event wins over a same-cycle write-one
  always_comb
  begin
    next_status = status;
    if (writeFire && hit(wrAddr, rtc_pkg::IDX_IRQ_STATUS) && wrStrb[0])
    begin
      next_status = status ^ wrData[rtc_pkg::IRQ_W-1:0]; // [RQ8] [RQ10]
    end
    if (compareEvent)
    begin
      next_status[rtc_pkg::IRQ_CMP_BIT] = 1'b1; // [RQ7]
    end
    if (periodicEvent)
    begin
      next_status[rtc_pkg::IRQ_PER_BIT] = 1'b1; // [RQ7]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status <= rtc_pkg::STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask <= rtc_pkg::MASK_RESET;
    end
    else if (writeFire && hit(wrAddr, rtc_pkg::IDX_IRQ_MASK) && wrStrb[0])
    begin
      mask <= wrData[rtc_pkg::IRQ_W-1:0];
    end
  end

  // Registered output keeps the pin glitch free at the cost of one cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status & mask); // [RQ11]
    end
  end

  // Read path: unused bits stay zero
  always_comb
  begin
    next_rdata = 32'h00000000; // [RQ9]
    next_rerr = 1'b0;
    if (hit(araddr, rtc_pkg::IDX_PERIOD))
    begin
      next_rdata[rtc_pkg::PCOUNT_W-1:0] = period;
    end
    else if (hit(araddr, rtc_pkg::IDX_PCOUNT_LOW))
    begin
      next_rdata[15:0] = downCount[15:0];
    end
    else if (hit(araddr, rtc_pkg::IDX_PCOUNT_HIGH))
    begin
      next_rdata[rtc_pkg::PCOUNT_HI_W-1:0] = downCount[rtc_pkg::PCOUNT_W-1:rtc_pkg::PCOUNT_HI_LSB]; // [RQ1]
    end
    else if (hit(araddr, rtc_pkg::IDX_UP_LOW))
    begin
      next_rdata[15:0] = upIf.value[15:0]; // [RQ6]
    end
    else if (hit(araddr, rtc_pkg::IDX_UP_HIGH))
    begin
      next_rdata[15:0] = upHighView; // [RQ6]
    end
    else if (hit(araddr, rtc_pkg::IDX_IRQ_STATUS))
    begin
      next_rdata[rtc_pkg::IRQ_W-1:0] = status; // [RQ7]
    end
    else if (hit(araddr, rtc_pkg::IDX_IRQ_MASK))
    begin
      next_rdata[rtc_pkg::IRQ_W-1:0] = mask;
    end
    else
    begin
      next_rerr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= rtc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rerr ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // Checks
  reset_stopped_a: assert property ($rose(nrst) |-> upIf.value == rtc_pkg::UP_RESET && !runEnable) // [RQ5]
    else $error("Up-counter not cleared and stopped after reset");

  periodic_upper_a: assert property (arvalid && arready && hit(araddr, rtc_pkg::IDX_PCOUNT_HIGH)
    |=> rdata == {24'h000000, $past(downCount[23:16])}) // [RQ1]
    else $error("Periodic upper byte read wrong");

  up_high_view_a: assert property (arvalid && arready && hit(araddr, rtc_pkg::IDX_UP_HIGH)
    |=> rdata[15] == $past(runEnable) && rdata[14:0] == $past(upIf.value[30:16]) && rdata[31:16] == 16'h0000) // [RQ6]
    else $error("Up-counter high word read wrong");

  status_reserved_a: assert property (arvalid && arready && hit(araddr, rtc_pkg::IDX_IRQ_STATUS)
    |=> rdata[31:2] == 30'h00000000 && rresp == rtc_pkg::RESP_OKAY) // [RQ9]
    else $error("Reserved status bits not zero");

  periodic_wrap_a: assert property (tick && downCount == 24'h000001
    |=> downCount == $past(period) ##1 status[0]) // [RQ12] [RQ7]
    else $error("Periodic counter did not reload and flag");

  down_step_a: assert property (tick && downCount > 24'h000001 |=> downCount == $past(downCount) - 24'h000001) // [RQ13]
    else $error("Periodic counter did not decrement");

  sw_trigger_a: assert property (writeFire && hit(wrAddr, rtc_pkg::IDX_IRQ_STATUS) && wrStrb[0]
    && wrData[0] && !status[0] |=> status[0] ##1 (irq || !$past(mask[0]))) // [RQ8]
    else $error("Software trigger did not raise the interrupt");

  w1c_clear_a: assert property (writeFire && hit(wrAddr, rtc_pkg::IDX_IRQ_STATUS) && wrStrb[0]
    && wrData[1] && status[1] && !compareEvent |=> !status[1]) // [RQ10]
    else $error("Write one did not clear the status bit");

  event_wins_a: assert property (compareEvent |=> status[1]) // [RQ10]
    else $error("Compare event lost against a clear");

  irq_level_a: assert property ((status & mask) != 2'h0 |=> irq) // [RQ11]
    else $error("Interrupt output missing for a pending status");

  irq_quiet_a: assert property ((status & mask) == 2'h0 |=> !irq) // [RQ11]
    else $error("Interrupt output high with nothing pending");

  read_latency_a: assert property (arvalid && arready |=> rvalid ##0 !arready) // [RQ9]
    else $error("Read answer late");

  periodic_wrap_c: cover property (tick && downCount == 24'h000001);
  sw_trigger_c: cover property (writeFire && hit(wrAddr, rtc_pkg::IDX_IRQ_STATUS) && wrData[0] && !status[0]);
  up_running_c: cover property (runEnable && tick ##1 upIf.value != 31'h00000000);
  irq_seen_c: cover property ($rose(irq));

endmodule

// ==== verification/tb_rtc_counter_regs.sv ====
// Purpose: Self-checking bench for the timer counter and interrupt register block
// Assumes: AXI4-Lite master tasks; slow timer ticks made as slow pulses
// Notes: Mask bit 1 lets a status bit reach irq; reset mask is 3
`timescale 1ns/1ps
module tb_rtc_counter_regs;
  localparam logic [31:0] IDX_NONE = 32'h0B0000E0;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic slowTimerClock = 1'b0, compareEvent = 1'b0;
  int failures = 0, checkCount = 0;
  logic [31:0] rd;

  always #5 sys_clk = ~sys_clk;

  rtc_counter_regs rtc_counter_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .slowTimerClock(slowTimerClock), .compareEvent(compareEvent), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together; bready held until the answer
  task automatic wr(input logic [31:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {idx[29:0], 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    bready <= 1'b0;
    if (n >= 100) failures++;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdr(input logic [31:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= {idx[29:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    rready <= 1'b0;
    if (n >= 100) failures++;
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input logic [31:0] idx, input logic [31:0] exp);
    logic [1:0] r;
    rdr(idx, rd, r);
    chk(rd, exp);
    chk({30'h0, r}, 32'h0);
  endtask

  // A tick is a rising edge of the slow clock seen by sys_clk
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      slowTimerClock <= 1'b1;
      repeat (2) @(posedge sys_clk);
      slowTimerClock <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end

  initial
  begin
    logic [1:0] r;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values and bus errors
    rchk(rtc_pkg::IDX_UP_LOW, 32'h0);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'h0);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h0);
    rchk(rtc_pkg::IDX_PCOUNT_HIGH, 32'h0);
    wr(IDX_NONE, 32'h1, 4'h3, rtc_pkg::RESP_SLVERR);
    rdr(IDX_NONE, rd, r);
    chk({30'h0, r}, {30'h0, rtc_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    $display("Test reset and bus done");
    // Up-counter enable, split and wrap
    tick(3);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h0);
    wr(rtc_pkg::IDX_UP_HIGH, 32'h8000, 4'h3, rtc_pkg::RESP_OKAY);
    tick(5);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h5);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'h8000);
    wr(rtc_pkg::IDX_UP_HIGH, 32'h0, 4'h3, rtc_pkg::RESP_OKAY);
    tick(2);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h5);
    wr(rtc_pkg::IDX_UP_LOW, 32'hFFFF, 4'h3, rtc_pkg::RESP_OKAY);
    wr(rtc_pkg::IDX_UP_HIGH, 32'h8000, 4'h3, rtc_pkg::RESP_OKAY);
    tick(1);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h0);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'h8001);
    wr(rtc_pkg::IDX_UP_LOW, 32'hFFFF, 4'h3, rtc_pkg::RESP_OKAY);
    wr(rtc_pkg::IDX_UP_HIGH, 32'hFFFF, 4'h3, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'hFFFF);
    tick(1);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h0);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'h8000);
    $display("Test up-counter done");
    // Periodic counter: reload at one, flag on the same tick
    wr(rtc_pkg::IDX_PERIOD, 32'h3, 4'h7, rtc_pkg::RESP_OKAY);
    tick(3);
    rchk(rtc_pkg::IDX_PCOUNT_LOW, 32'h1);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h0);
    tick(1);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h1);
    rchk(rtc_pkg::IDX_PCOUNT_LOW, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(rtc_pkg::IDX_IRQ_MASK, 32'h0, 4'h1, rtc_pkg::RESP_OKAY);
    // irq is registered, so it follows the mask one edge after the write lands
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(rtc_pkg::IDX_IRQ_MASK, 32'h3, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h1, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(rtc_pkg::IDX_PERIOD, 32'h120000, 4'h7, rtc_pkg::RESP_OKAY);
    tick(3);
    rchk(rtc_pkg::IDX_PCOUNT_HIGH, 32'h12);
    wr(rtc_pkg::IDX_PCOUNT_HIGH, 32'h5, 4'h3, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_PCOUNT_HIGH, 32'h12);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h1);
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h1, 4'h1, rtc_pkg::RESP_OKAY);
    $display("Test periodic done");
    // Software trigger, compare event, write-one clear
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h2, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h2, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h0);
    @(posedge sys_clk);
    compareEvent <= 1'b1;
    @(posedge sys_clk);
    compareEvent <= 1'b0;
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h2);
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h0, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h2);
    wr(rtc_pkg::IDX_IRQ_STATUS, 32'h2, 4'h1, rtc_pkg::RESP_OKAY);
    rchk(rtc_pkg::IDX_IRQ_STATUS, 32'h0);
    $display("Test status done");
    // Second reset while counting stops and clears the counter
    wr(rtc_pkg::IDX_UP_HIGH, 32'h8000, 4'h3, rtc_pkg::RESP_OKAY);
    tick(2);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(2);
    rchk(rtc_pkg::IDX_UP_LOW, 32'h0);
    rchk(rtc_pkg::IDX_UP_HIGH, 32'h0);
    $display("Test second reset done");
    print_verdict;
  end
endmodule
